// ==== hw/seg_pkg.sv ====
// seg_pkg: constants, carrier structs and decode helpers for the servo
// enable / overtravel gate.
// assumes a single 125 MHz clock and apb software access.
package seg_pkg;

    localparam int unsigned CLK_MHZ = 125;

    // register byte addresses
    localparam logic [7:0] BASIC_FUNCTION_CFG_ADDR = 8'h00;
    localparam logic [7:0] STOP_ACTION_CFG_ADDR = 8'h04;
    localparam logic [7:0] INPUT_ASSIGN_CFG_A_ADDR = 8'h08;
    localparam logic [7:0] INPUT_ASSIGN_CFG_B_ADDR = 8'h0c;
    localparam logic [7:0] CONTROL_ADDR = 8'h10;
    localparam logic [7:0] STATUS_ADDR = 8'h14;

    // values after reset
    localparam logic [15:0] BASIC_FUNCTION_CFG_RST = 16'h0000;
    localparam logic [15:0] STOP_ACTION_CFG_RST = 16'h0000;
    localparam logic [15:0] INPUT_ASSIGN_CFG_A_RST = 16'h2000;
    localparam logic [15:0] INPUT_ASSIGN_CFG_B_RST = 16'h0003;

    // nibble positions of the fields
    localparam logic [1:0] DIR_NIB = 2'h0;
    localparam logic [1:0] CTRL_MODE_NIB = 2'h1;
    localparam logic [1:0] STOP_MODE_NIB = 2'h1;
    localparam logic [1:0] EN_SRC_NIB = 2'h1;
    localparam logic [1:0] FWD_LIM_NIB = 2'h3;
    localparam logic [1:0] REV_LIM_NIB = 2'h0;

    // field codes
    localparam logic [3:0] DIR_REVERSED = 4'h1;
    localparam logic [3:0] CTRL_POSITION = 4'h1;
    localparam logic [3:0] STOP_ZERO_CLAMP = 4'h1;
    localparam logic [3:0] EN_SRC_ALWAYS = 4'h7;
    localparam logic [3:0] LIM_DISABLED = 4'h8;

    // control register bits
    localparam int unsigned CTL_RESTART_BIT = 0;
    localparam int unsigned CTL_ALARM_CLR_BIT = 1;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_STOPPING,
        ST_CLAMP,
        ST_BLOCK
    } seg_stop_e;

    // pins from outside the clock domain
    typedef struct packed {
        logic servoOnN;
        logic fwdLimitIn;
        logic revLimitIn;
        logic errorClearIn;
        logic mainPowerOk;
    } seg_pins_s;

    localparam seg_pins_s SEG_PINS_RST = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

    // same-clock requests from the motion core
    typedef struct packed {
        logic refFwd;
        logic refRev;
        logic stepFwd;
        logic stepRev;
        logic motorStopped;
        logic alarm;
    } seg_core_s;

    // configuration in force since the last restart
    typedef struct packed {
        logic enForced;
        logic fwdUsed;
        logic revUsed;
        logic dirRev;
        logic posMode;
        logic zeroClamp;
    } seg_act_s;

    typedef struct packed {
        logic motorPower;
        logic motorDrive;
        logic runFwd;
        logic runRev;
        logic physReverse;
        logic zeroClampHold;
        logic baseBlock;
        logic holdError;
        logic brakeReleaseOut;
        logic fwdOvertravel;
        logic revOvertravel;
    } seg_drive_s;

    function automatic logic [3:0] segNib(input logic [15:0] v,
                                          input logic [1:0] idx);
        segNib = v[{idx, 2'b00} +: 4];
    endfunction

    function automatic seg_act_s segDecode(input logic [15:0] basic,
                                           input logic [15:0] stopCfg,
                                           input logic [15:0] cfgA,
                                           input logic [15:0] cfgB);
        seg_act_s a;
        a.enForced = segNib(cfgA, EN_SRC_NIB) == EN_SRC_ALWAYS;
        a.fwdUsed = segNib(cfgA, FWD_LIM_NIB) != LIM_DISABLED;
        a.revUsed = segNib(cfgB, REV_LIM_NIB) != LIM_DISABLED;
        a.dirRev = segNib(basic, DIR_NIB) == DIR_REVERSED;
        a.posMode = segNib(basic, CTRL_MODE_NIB) == CTRL_POSITION;
        a.zeroClamp = segNib(stopCfg, STOP_MODE_NIB) == STOP_ZERO_CLAMP;
        segDecode = a;
    endfunction

endpackage

// ==== hw/seg_pin_sync.sv ====
// seg_pin_sync: two-flop synchroniser for the gate's pin inputs.
// assumes the pins change without regard to clock.
module seg_pin_sync
    import seg_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // pins
    input wire seg_pins_s pinsIn,
    output seg_pins_s pinsSync
);

    typedef struct packed {
        seg_pins_s meta;
        seg_pins_s stable;
    } seg_sync_state_s;

    seg_sync_state_s state_q;
    seg_sync_state_s state_d;

    // first stage feeds only the second stage
    always_comb begin
        state_d = state_q;
        state_d.meta = pinsIn;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= '{SEG_PINS_RST, SEG_PINS_RST};
        end else begin
            state_q <= state_d;
        end
    end

    assign pinsSync = state_q.stable;

endmodule

// ==== hw/seg_enc_out.sv ====
// seg_enc_out: quadrature encoder pulse output from step pulses.
// assumes steps are given in reference-direction terms, one per cycle.
module seg_enc_out
    import seg_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // steps
    input wire logic stepFwd,
    input wire logic stepRev,
    // outputs
    output logic encOutPhaseA,
    output logic encOutPhaseB
);

    typedef struct packed {
        logic phA;
        logic phB;
    } seg_enc_state_s;

    seg_enc_state_s state_q;
    seg_enc_state_s state_d;

    // forward walks 00,01,11,10 so phase b leads phase a
    always_comb begin
        state_d = state_q;
        if (stepFwd && !stepRev) begin
            state_d.phA = state_q.phB;
            state_d.phB = !state_q.phA;
        end else if (stepRev && !stepFwd) begin
            state_d.phA = !state_q.phB;
            state_d.phB = state_q.phA;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= '{1'b0, 1'b0};
        end else begin
            state_q <= state_d;
        end
    end

    assign encOutPhaseA = state_q.phA;
    assign encOutPhaseB = state_q.phB;

endmodule

// ==== hw/seg_gate.sv ====
// seg_gate: servo enable and overtravel gating with apb registers.
// assumes pins arrive asynchronously, core requests on this clock.
//
// Overview of operation
// - motor powered and operable only while servo enable holds.
// - enable comes from terminal or is forced permanently by configuration.
// - forced enable powers motor as soon as main supply is up.
// - clearing an alarm re-enables power at once if enable holds.
// - direction field swaps physical rotation, encoder polarity unchanged.
// - default direction takes counterclockwise from load end as forward.
// - encoder shows b leading for forward, a leading for reverse.
// - forward limit low inhibits forward motion, enters forward overtravel.
// - reverse limit low inhibits reverse motion, enters reverse overtravel.
// - opposite-direction references still run during overtravel.
// - overtravel stop in position mode holds error until clear input.
// - forward limit input may be ignored, permitting forward always.
// - reverse limit input may be ignored, permitting reverse always.
// - brake release stays asserted throughout overtravel.
// - default stop setting removes drive, base block after stopping.
// - zero clamp setting holds zero clamp after overtravel stop.
// - zero clamp closes position loop on a zero reference.
//
// Register access over APB and the register addresses were decided locally.
module seg_gate
    import seg_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire seg_pins_s pinsIn,
    // motion core
    input wire seg_core_s coreIn,
    // gating outputs
    output seg_drive_s driveOut,
    output logic encOutPhaseA,
    output logic encOutPhaseB
);

    typedef struct packed {
        logic [15:0] basicCfg;
        logic [15:0] stopCfg;
        logic [15:0] assignCfgA;
        logic [15:0] assignCfgB;
        seg_act_s act;
        seg_stop_e stopState;
        logic alarm;
        logic holdErr;
        logic power;
        logic [31:0] rdata;
        logic slvErr;
        seg_drive_s drv;
    } seg_gate_state_s;

    seg_gate_state_s state_q;
    seg_gate_state_s state_d;
    seg_pins_s pins;

    function automatic logic segMapped(input logic [7:0] a);
        segMapped = (a == BASIC_FUNCTION_CFG_ADDR)
            || (a == STOP_ACTION_CFG_ADDR)
            || (a == INPUT_ASSIGN_CFG_A_ADDR)
            || (a == INPUT_ASSIGN_CFG_B_ADDR)
            || (a == CONTROL_ADDR)
            || (a == STATUS_ADDR);
    endfunction

    seg_pin_sync u_sync (
        .clock(clock),
        .rst(rst),
        .pinsIn(pinsIn),
        .pinsSync(pins)
    );

    // encoder follows the reference-sense steps, never the direction field
    seg_enc_out u_enc (
        .clock(clock),
        .rst(rst),
        .stepFwd(coreIn.stepFwd),
        .stepRev(coreIn.stepRev),
        .encOutPhaseA(encOutPhaseA),
        .encOutPhaseB(encOutPhaseB)
    );

    logic setup;
    logic wrAccess;
    logic restart;
    logic alarmClr;
    logic enCond;
    logic fwdOt;
    logic revOt;
    logic anyOt;
    logic oppositeRef;
    logic moving;
    logic [31:0] statusWord;

    always_comb begin
        state_d = state_q;
        setup = psel && !penable;
        wrAccess = psel && penable && pwrite && segMapped(paddr);
        restart = wrAccess && (paddr == CONTROL_ADDR)
            && pwdata[CTL_RESTART_BIT];
        alarmClr = wrAccess && (paddr == CONTROL_ADDR)
            && pwdata[CTL_ALARM_CLR_BIT];

        // register writes take effect at the access edge
        if (wrAccess) begin
            unique case (paddr)
                BASIC_FUNCTION_CFG_ADDR: begin
                    state_d.basicCfg = pwdata[15:0];
                end
                STOP_ACTION_CFG_ADDR: begin
                    state_d.stopCfg = pwdata[15:0];
                end
                INPUT_ASSIGN_CFG_A_ADDR: begin
                    state_d.assignCfgA = pwdata[15:0];
                end
                INPUT_ASSIGN_CFG_B_ADDR: begin
                    state_d.assignCfgB = pwdata[15:0];
                end
                default: begin
                end
            endcase
        end

        // live fields are only copied in on restart, even mid-run, never on a config register write
        if (restart) begin
            state_d.act = segDecode(state_q.basicCfg, state_q.stopCfg,
                state_q.assignCfgA, state_q.assignCfgB);
        end

        // alarm set beats clear in the same cycle
        state_d.alarm = coreIn.alarm || (state_q.alarm && !alarmClr);

        // forced source ignores the terminal entirely
        enCond = pins.mainPowerOk
            && (state_q.act.enForced || !pins.servoOnN);
        // power follows the cleared alarm in the same edge
        state_d.power = enCond && !state_d.alarm;

        // limit pins are high while travel is allowed
        fwdOt = state_q.act.fwdUsed && !pins.fwdLimitIn;
        revOt = state_q.act.revUsed && !pins.revLimitIn;
        anyOt = fwdOt || revOt;
        oppositeRef = (fwdOt && !revOt && coreIn.refRev)
            || (revOt && !fwdOt && coreIn.refFwd);

        // stop sequence after a limit is hit
        if (!state_d.power) begin
            state_d.stopState = ST_RUN;
        end else begin
            unique case (state_q.stopState)
                ST_RUN: begin
                    if (anyOt && !oppositeRef) begin
                        state_d.stopState = ST_STOPPING;
                    end
                end
                ST_STOPPING: begin
                    if (!anyOt || oppositeRef) begin
                        state_d.stopState = ST_RUN;
                    end else if (coreIn.motorStopped) begin
                        if (state_q.act.zeroClamp) begin
                            state_d.stopState = ST_CLAMP;
                        end else begin
                            state_d.stopState = ST_BLOCK;
                        end
                    end
                end
                ST_CLAMP, ST_BLOCK: begin
                    if (!anyOt || oppositeRef) begin
                        state_d.stopState = ST_RUN;
                    end
                end
            endcase
        end

        // error is kept on a position-mode limit stop; set beats clear
        if (state_q.power && state_q.act.posMode
            && state_q.stopState == ST_STOPPING
            && state_d.stopState != ST_STOPPING
            && state_d.stopState != ST_RUN) begin
            state_d.holdErr = 1'b1;
        end else if (pins.errorClearIn) begin
            state_d.holdErr = 1'b0;
        end

        moving = state_d.power && (state_d.stopState == ST_RUN
            || state_d.stopState == ST_STOPPING);

        // apb read data and error are latched in the setup cycle
        statusWord = '0;
        statusWord[0] = state_q.power;
        statusWord[1] = fwdOt;
        statusWord[2] = revOt;
        statusWord[3] = state_q.holdErr;
        statusWord[4] = state_q.alarm;
        statusWord[5] = state_q.stopState == ST_CLAMP;
        statusWord[6] = state_q.stopState == ST_BLOCK;
        statusWord[7] = state_q.act.enForced;
        statusWord[8] = state_q.act.dirRev;
        statusWord[9] = state_q.act.fwdUsed;
        statusWord[10] = state_q.act.revUsed;
        statusWord[11] = state_q.act.zeroClamp;
        statusWord[12] = state_q.act.posMode;
        statusWord[13] = !pins.servoOnN;
        statusWord[14] = pins.fwdLimitIn;
        statusWord[15] = pins.revLimitIn;
        statusWord[16] = pins.mainPowerOk;
        if (setup) begin
            state_d.slvErr = !segMapped(paddr);
            unique case (paddr)
                BASIC_FUNCTION_CFG_ADDR: begin
                    state_d.rdata = {16'h0000, state_q.basicCfg};
                end
                STOP_ACTION_CFG_ADDR: begin
                    state_d.rdata = {16'h0000, state_q.stopCfg};
                end
                INPUT_ASSIGN_CFG_A_ADDR: begin
                    state_d.rdata = {16'h0000, state_q.assignCfgA};
                end
                INPUT_ASSIGN_CFG_B_ADDR: begin
                    state_d.rdata = {16'h0000, state_q.assignCfgB};
                end
                STATUS_ADDR: begin
                    state_d.rdata = statusWord;
                end
                default: begin
                    state_d.rdata = 32'h0000_0000;
                end
            endcase
        end

        // drive outputs, registered
        state_d.drv.motorPower = state_d.power;
        state_d.drv.motorDrive = moving
            || (state_d.power && state_d.stopState == ST_CLAMP);
        state_d.drv.runFwd = moving && coreIn.refFwd && !fwdOt;
        state_d.drv.runRev = moving && coreIn.refRev && !revOt;
        // direction field swaps the winding sense only
        state_d.drv.physReverse = state_d.act.dirRev;
        // zero clamp asks the loop for a zero position reference
        state_d.drv.zeroClampHold = state_d.power
            && state_d.stopState == ST_CLAMP;
        state_d.drv.baseBlock = state_d.power
            && state_d.stopState == ST_BLOCK;
        state_d.drv.holdError = state_d.holdErr;
        // brake is released whenever power is on, overtravel or not
        state_d.drv.brakeReleaseOut = state_d.power;
        state_d.drv.fwdOvertravel = fwdOt;
        state_d.drv.revOvertravel = revOt;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q.basicCfg <= BASIC_FUNCTION_CFG_RST;
            state_q.stopCfg <= STOP_ACTION_CFG_RST;
            state_q.assignCfgA <= INPUT_ASSIGN_CFG_A_RST;
            state_q.assignCfgB <= INPUT_ASSIGN_CFG_B_RST;
            state_q.act <= segDecode(BASIC_FUNCTION_CFG_RST,
                STOP_ACTION_CFG_RST, INPUT_ASSIGN_CFG_A_RST,
                INPUT_ASSIGN_CFG_B_RST);
            state_q.stopState <= ST_RUN;
            state_q.alarm <= 1'b0;
            state_q.holdErr <= 1'b0;
            state_q.power <= 1'b0;
            state_q.rdata <= 32'h0000_0000;
            state_q.slvErr <= 1'b0;
            state_q.drv <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // zero wait states: the answer is ready in the first access cycle
    assign pready = 1'b1;
    assign prdata = state_q.rdata;
    assign pslverr = state_q.slvErr && psel && penable;
    assign driveOut = state_q.drv;

endmodule

// ==== tb/seg_gate_sva.sv ====
// seg_gate_sva: concurrent checks on the gate's outputs against causes.
// assumes it is bound to seg_gate and sees only its ports.
module seg_gate_sva
    import seg_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // observed ports
    input wire seg_pins_s pinsIn,
    input wire seg_core_s coreIn,
    input wire seg_drive_s driveOut,
    input wire logic encOutPhaseA,
    input wire logic encOutPhaseB
);
    timeunit 1ns;
    timeprecision 100ps;
    // pin checks wait out the synchroniser's reset values
    logic [2:0] upCnt_q;
    logic settled;
    always_ff @(posedge clock) begin
        if (rst) begin
            upCnt_q <= 3'h0;
        end else if (upCnt_q != 3'h7) begin
            upCnt_q <= upCnt_q + 3'h1;
        end
    end
    assign settled = upCnt_q == 3'h7;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_brake_tracks_power: assert property (
        driveOut.brakeReleaseOut == driveOut.motorPower)
        else $error("brake release differs from motor power");
    a_power_needs_supply: assert property (
        settled && driveOut.motorPower |-> $past(pinsIn.mainPowerOk, 3))
        else $error("motor power without main supply");
    a_alarm_cuts_power: assert property (
        coreIn.alarm |=> !driveOut.motorPower)
        else $error("motor power kept during alarm");
    a_fwd_run_blocked: assert property (
        driveOut.fwdOvertravel |-> !driveOut.runFwd)
        else $error("forward run during forward overtravel");
    a_rev_run_blocked: assert property (
        driveOut.revOvertravel |-> !driveOut.runRev)
        else $error("reverse run during reverse overtravel");
    a_fwd_ot_cause: assert property (
        settled && driveOut.fwdOvertravel |-> !$past(pinsIn.fwdLimitIn, 3))
        else $error("forward overtravel without limit input");
    a_rev_ot_cause: assert property (
        settled && driveOut.revOvertravel |-> !$past(pinsIn.revLimitIn, 3))
        else $error("reverse overtravel without limit input");
    a_run_needs_ref: assert property (
        driveOut.runRev |-> $past(coreIn.refRev) && driveOut.motorPower)
        else $error("reverse run without reference or power");
    a_block_no_drive: assert property (
        driveOut.baseBlock |-> !driveOut.motorDrive && !driveOut.zeroClampHold)
        else $error("drive or clamp during base block");
    a_enc_fwd_step: assert property (
        coreIn.stepFwd && !coreIn.stepRev |=> encOutPhaseA ==
        $past(encOutPhaseB) && encOutPhaseB == !$past(encOutPhaseA))
        else $error("forward step gave wrong phase order");
    a_enc_rev_step: assert property (
        coreIn.stepRev && !coreIn.stepFwd |=> encOutPhaseA ==
        !$past(encOutPhaseB) && encOutPhaseB == $past(encOutPhaseA))
        else $error("reverse step gave wrong phase order");
    a_enc_hold: assert property (
        !coreIn.stepFwd && !coreIn.stepRev |=>
        $stable(encOutPhaseA) && $stable(encOutPhaseB))
        else $error("encoder moved without a step");
endmodule

bind seg_gate seg_gate_sva chk (
    .clock(clock),
    .rst(rst),
    .pinsIn(pinsIn),
    .coreIn(coreIn),
    .driveOut(driveOut),
    .encOutPhaseA(encOutPhaseA),
    .encOutPhaseB(encOutPhaseB)
);

// ==== tb/seg_host_model.sv ====
// seg_host_model: host controller and limit switches facing the gate.
// assumes the bench sets wanted pin levels and motion requests.
module seg_host_model
    import seg_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // requests from the bench
    input wire seg_pins_s pinsWant,
    input wire logic wantFwd,
    input wire logic wantRev,
    input wire logic alarmReq,
    // device side
    input wire seg_drive_s driveOut,
    output seg_pins_s pinsIn,
    output seg_core_s coreIn
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        pinsIn = SEG_PINS_RST;
        coreIn = '0;
    end
    always @(posedge clock) begin
        if (rst) begin
            pinsIn <= SEG_PINS_RST;
            coreIn <= '0;
        end else begin
            // enable only changes with the shaft at rest
            pinsIn <= {coreIn.motorStopped ? pinsWant.servoOnN
                : pinsIn.servoOnN, pinsWant[3:0]};
            // no reference before power is on
            coreIn.refFwd <= wantFwd & driveOut.motorPower;
            coreIn.refRev <= wantRev & driveOut.motorPower;
            // a step every other cycle: slow, so every edge is seen
            coreIn.stepFwd <= driveOut.runFwd & ~coreIn.stepFwd;
            coreIn.stepRev <= driveOut.runRev & ~coreIn.stepRev;
            coreIn.motorStopped <= ~(driveOut.runFwd | driveOut.runRev);
            coreIn.alarm <= alarmReq;
        end
    end
endmodule

// ==== tb/seg_gate_test.sv ====
// seg_gate_test: self-checking bench for the enable / overtravel gate.
// assumes the host model drives pins and core; apb is driven here.
module seg_gate_test
    import seg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    seg_pins_s pinsIn, pinsWant;
    seg_core_s coreIn;
    seg_drive_s driveOut, dS;
    logic encA, encB, wantFwd, wantRev, alarmReq, se;
    logic [1:0] encS;
    int errors, checks_done;
    logic [7:0] adr [4] = '{BASIC_FUNCTION_CFG_ADDR, STOP_ACTION_CFG_ADDR,
        INPUT_ASSIGN_CFG_A_ADDR, INPUT_ASSIGN_CFG_B_ADDR};
    logic [15:0] rv [4] = '{BASIC_FUNCTION_CFG_RST, STOP_ACTION_CFG_RST,
        INPUT_ASSIGN_CFG_A_RST, INPUT_ASSIGN_CFG_B_RST};

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // drive and encoder outputs are read from a mid-cycle copy, never at the edge
    always @(negedge clock) begin
        dS <= driveOut;
        encS <= {encA, encB};
    end

    seg_gate uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pinsIn(pinsIn),
        .coreIn(coreIn), .driveOut(driveOut), .encOutPhaseA(encA),
        .encOutPhaseB(encB));
    seg_host_model host (.clock(clock), .rst(rst), .pinsWant(pinsWant),
        .wantFwd(wantFwd), .wantRev(wantRev), .alarmReq(alarmReq),
        .driveOut(driveOut), .pinsIn(pinsIn), .coreIn(coreIn));

    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [1:0] encNext(input logic [1:0] ab,
                                           input logic fwd);
        return fwd ? {ab[0], ~ab[1]} : {~ab[0], ab[1]};
    endfunction
    task automatic encTrack(input logic fwd);
        logic [1:0] s;
        int n;
        repeat (4) begin
            s = encS;
            n = 0;
            while (encS === s && n < 40) begin
                @(posedge clock);
                n++;
            end
            chk({30'h0, encS}, {30'h0, encNext(s, fwd)});
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        finish_test();
    end

    initial begin
        logic [31:0] v;
        logic f, r;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {wantFwd, wantRev, alarmReq} = '0;
        pinsWant = SEG_PINS_RST;
        errors = 0;
        checks_done = 0;
        v = $urandom(32'h57e7);
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, adr[i], 32'h0);
            chk(rd, {16'h0, rv[i]});
            chkb(se, 1'b0);
            v = $urandom;
            apb(1'b1, adr[i], v);
            apb(1'b0, adr[i], 32'h0);
            chk(rd, {16'h0, v[15:0]});
            apb(1'b1, adr[i], {16'h0, rv[i]});
        end
        apb(1'b1, 8'h18, $urandom);
        apb(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        chkb(se, 1'b1);
        $display("register test done");
        pinsWant <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        step(8);
        chkb(dS.motorPower, 1'b0);
        pinsWant.servoOnN <= 1'b0;
        step(8);
        chkb(dS.motorPower, 1'b1);
        chkb(dS.brakeReleaseOut, 1'b1);
        wantFwd <= 1'b1;
        step(6);
        chkb(dS.runFwd, 1'b1);
        chkb(dS.physReverse, 1'b0);
        encTrack(1'b1);
        $display("enable test done");
        pinsWant.fwdLimitIn <= 1'b0;
        step(6);
        chkb(dS.runFwd, 1'b0);
        chkb(dS.fwdOvertravel, 1'b1);
        chkb(dS.brakeReleaseOut, 1'b1);
        step(8);
        chkb(dS.baseBlock, 1'b1);
        chkb(dS.motorDrive, 1'b0);
        wantFwd <= 1'b0;
        wantRev <= 1'b1;
        step(6);
        chkb(dS.runRev, 1'b1);
        encTrack(1'b0);
        $display("overtravel test done");
        repeat (40) begin
            {f, r} = 2'($urandom);
            pinsWant.fwdLimitIn <= f;
            pinsWant.revLimitIn <= r;
            {wantFwd, wantRev} <= 2'($urandom);
            step(6);
            chkb(dS.fwdOvertravel, ~f);
            chkb(dS.revOvertravel, ~r);
        end
        {wantFwd, wantRev} <= 2'b00;
        pinsWant <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        apb(1'b1, adr[0], 32'h0011);
        apb(1'b1, adr[1], 32'h0010);
        apb(1'b1, adr[2], 32'h8070);
        apb(1'b1, adr[3], 32'h0008);
        step(8);
        chkb(dS.motorPower, 1'b0);
        chkb(dS.fwdOvertravel, 1'b1);
        apb(1'b1, CONTROL_ADDR, 32'h1);
        step(8);
        chkb(dS.motorPower, 1'b1);
        chkb(dS.physReverse, 1'b1);
        chkb(dS.fwdOvertravel, 1'b0);
        chkb(dS.revOvertravel, 1'b0);
        wantFwd <= 1'b1;
        step(6);
        chkb(dS.runFwd, 1'b1);
        encTrack(1'b1);
        wantFwd <= 1'b0;
        // limit closed before the restart arms it: no stray stop
        pinsWant.revLimitIn <= 1'b1;
        apb(1'b1, adr[3], 32'h0003);
        apb(1'b1, CONTROL_ADDR, 32'h1);
        step(8);
        wantRev <= 1'b1;
        step(6);
        chkb(dS.runRev, 1'b1);
        pinsWant.revLimitIn <= 1'b0;
        step(16);
        chkb(dS.zeroClampHold, 1'b1);
        chkb(dS.baseBlock, 1'b0);
        chkb(dS.holdError, 1'b1);
        pinsWant.errorClearIn <= 1'b1;
        step(8);
        chkb(dS.holdError, 1'b0);
        pinsWant.errorClearIn <= 1'b0;
        wantRev <= 1'b0;
        $display("configuration test done");
        alarmReq <= 1'b1;
        step(1);
        alarmReq <= 1'b0;
        step(4);
        chkb(dS.motorPower, 1'b0);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk({30'h0, rd[4], rd[0]}, 32'h2);
        apb(1'b1, CONTROL_ADDR, 32'h2);
        step(2);
        chkb(dS.motorPower, 1'b1);
        $display("alarm test done");
        finish_test();
    end
endmodule
